/* File: shared/pcit_pkg.sv */
// shared constants and types for the instruction timing sequencer
package pcit_pkg;

  // sequencer states, one-hot
  typedef enum logic [1:0] {
    PCIT_ST_BOOT = 2'h1,  // first cycle after reset, program address settles
    PCIT_ST_RUN  = 2'h2   // instructions are being sequenced
  } pcit_state_type;

  // timing class of an opcode, steers address generation
  typedef enum logic [3:0] {
    PCIT_CLS_SEQ     = 4'h0,  // straight line, next opcode follows
    PCIT_CLS_COND    = 4'h1,  // conditional relative branch
    PCIT_CLS_REL     = 4'h2,  // unconditional relative branch
    PCIT_CLS_ABS11   = 4'h3,  // branch inside the 2 kB page of the following instruction
    PCIT_CLS_ABS16   = 4'h4,  // branch to a full 16-bit address
    PCIT_CLS_JMP_IND = 4'h5,  // branch to accumulator plus data pointer
    PCIT_CLS_RET     = 4'h6,  // branch to a popped return address
    PCIT_CLS_CODE_RD = 4'h7,  // code byte read through the program bus
    PCIT_CLS_EXT     = 4'h8   // external data move
  } pcit_class_type;

  typedef logic [15:0] pcit_addr_type;  // program and data pointer width
  typedef logic [1:0]  pcit_len_type;   // instruction length in bytes
  typedef logic [3:0]  pcit_cyc_type;   // cycle count and cycle index
  typedef logic [7:0]  pcit_byte_type;  // one program byte

  // instruction lengths
  localparam pcit_len_type LEN_1 = 2'h1;
  localparam pcit_len_type LEN_2 = 2'h2;
  localparam pcit_len_type LEN_3 = 2'h3;

  // cycle counts and cycle indexes
  localparam pcit_cyc_type CYC_FIRST = 4'h0;  // index of the opcode cycle
  localparam pcit_cyc_type CYC_1     = 4'h1;
  localparam pcit_cyc_type CYC_2     = 4'h2;
  localparam pcit_cyc_type CYC_3     = 4'h3;
  localparam pcit_cyc_type CYC_4     = 4'h4;
  localparam pcit_cyc_type CYC_RET   = 4'h5;
  localparam pcit_cyc_type CYC_DIV   = 4'h8;
  localparam pcit_cyc_type CYC_MUL   = 4'h4;

  // cycle indexes at which the sequencer acts
  localparam pcit_cyc_type IDX_OPND1   = 4'h1;  // first operand byte on the bus
  localparam pcit_cyc_type IDX_OPND2   = 4'h2;  // second operand byte on the bus
  localparam pcit_cyc_type IDX_CODE_AD = 4'h1;  // code read address goes out
  localparam pcit_cyc_type IDX_CODE_DT = 4'h2;  // code read byte comes back
  localparam pcit_cyc_type IDX_XDATA   = 4'h1;  // external move strobe

  // reset values
  localparam pcit_addr_type RESET_PC   = 16'h0000;
  localparam pcit_byte_type RESET_BYTE = 8'h00;

  // opcode field positions
  localparam int unsigned OPC_XWRITE_BIT = 4;   // external move writes when set
  localparam int unsigned OPC_XNARROW_BIT = 1;  // external move uses 8-bit pointer
  localparam int unsigned OPC_DATA_POINTER_16_BIT   = 4;   // code read based on data pointer
  localparam int unsigned OPC_PAGE_MSB   = 7;   // top of in-page address field
  localparam int unsigned OPC_PAGE_LSB   = 5;   // bottom of in-page address field
  localparam int unsigned PC_PAGE_LSB    = 11;  // lowest bit kept by an in-page branch

endpackage

/* File: rtl/pcit_timing_decode.sv */
`timescale 1ns/10ps
`default_nettype none
// length, cycle count and timing class of one opcode byte
module pcit_timing_decode (
  input  wire pcit_pkg::pcit_byte_type opc_byte,
  output pcit_pkg::pcit_len_type       dec_len,
  output pcit_pkg::pcit_cyc_type       dec_cyc,
  output pcit_pkg::pcit_class_type     dec_cls
);
  import pcit_pkg::*;

  // first matching pattern wins, so exceptions stand above their column
  always_comb begin
    dec_len = LEN_1;
    dec_cyc = CYC_1;
    dec_cls = PCIT_CLS_SEQ;
    casez (opc_byte)
      8'h00, 8'ha5 : begin  // no-operation and its unused twin
        dec_len = LEN_1;
        dec_cyc = CYC_1;
      end
      8'b???0_0001, 8'b???1_0001 : begin  // in-page jump and call
        dec_len = LEN_2;
        dec_cyc = CYC_3;
        dec_cls = PCIT_CLS_ABS11;
      end
      8'h02, 8'h12 : begin  // long jump and call
        dec_len = LEN_3;
        dec_cyc = CYC_4;
        dec_cls = PCIT_CLS_ABS16;
      end
      8'h22, 8'h32 : begin  // returns
        dec_cyc = CYC_RET;
        dec_cls = PCIT_CLS_RET;
      end
      8'h10, 8'h20, 8'h30, 8'hb4, 8'b1011_1???, 8'hd5 : begin  // bit, compare, count
        dec_len = LEN_3;
        dec_cyc = CYC_3;
        dec_cls = PCIT_CLS_COND;
      end
      8'hb5, 8'b1011_011? : begin  // compares that read RAM first
        dec_len = LEN_3;
        dec_cyc = CYC_4;
        dec_cls = PCIT_CLS_COND;
      end
      8'h40, 8'h50, 8'h60, 8'h70, 8'b1101_1??? : begin  // short tests
        dec_len = LEN_2;
        dec_cyc = CYC_2;
        dec_cls = PCIT_CLS_COND;
      end
      8'h80 : begin  // short jump
        dec_len = LEN_2;
        dec_cyc = CYC_3;
        dec_cls = PCIT_CLS_REL;
      end
      8'h73 : begin  // jump to accumulator plus pointer
        dec_cyc = CYC_3;
        dec_cls = PCIT_CLS_JMP_IND;
      end
      8'h83, 8'h93 : begin  // code byte read
        dec_cyc = CYC_3;
        dec_cls = PCIT_CLS_CODE_RD;
      end
      8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3 : begin  // external moves
        dec_cyc = CYC_3;
        dec_cls = PCIT_CLS_EXT;
      end
      8'h84 : dec_cyc = CYC_DIV;  // divide
      8'ha4 : dec_cyc = CYC_MUL;  // multiply
      8'h90, 8'h85, 8'h75, 8'h43, 8'h53, 8'h63 : begin
        dec_len = LEN_3;
        dec_cyc = CYC_3;
      end
      8'b????0000, 8'b????0010 : begin  // push, pop, bit ops
        dec_len = LEN_2;
        dec_cyc = CYC_2;
      end
      8'b????0011, 8'b000?0100, 8'b11??0100 : begin
        dec_len = LEN_1;
        dec_cyc = CYC_1;
      end
      8'b????0100, 8'b????0101 : begin  // immediate and direct forms
        dec_len = LEN_2;
        dec_cyc = CYC_2;
      end
      8'b0111_011?, 8'b1000_011?, 8'b1010_011? : begin  // indirect with a byte
        dec_len = LEN_2;
        dec_cyc = CYC_2;
      end
      8'b????011? : begin  // indirect RAM
        dec_len = LEN_1;
        dec_cyc = CYC_2;
      end
      8'b0111_1???, 8'b1000_1???, 8'b1010_1??? : begin
        dec_len = LEN_2;
        dec_cyc = CYC_2;
      end
      default : begin  // bank register forms
        dec_len = LEN_1;
        dec_cyc = CYC_1;
      end
    endcase
  end

endmodule
`default_nettype wire

/* File: rtl/pcit_core_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - one counter step per system clock
// - default: one cycle per instruction byte
// - untaken conditional branch ends one cycle early
// - indirect RAM arithmetic/logic: one byte, two cycles
// - register forms one cycle, direct forms two
// - logic immediate into direct byte: three cycles
// - logic accumulator into direct byte: two cycles
// - accumulator-only operations: one byte, one cycle
// - code byte read: one byte, three cycles
// - all external data moves take three cycles
// - load data pointer immediate: three cycles
// - direct to direct move: three cycles
// - store accumulator indirect: two cycles
// - load bank register immediate: two cycles
// - push and pop: two bytes, two cycles
// - indirect exchanges: one byte, two cycles
// - relative offset signed, from next instruction
// - unused opcode behaves as no-operation
module pcit_core_sequencer (
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  input  wire pcit_pkg::pcit_byte_type  code_rdata,
  input  wire logic                     branch_cond,
  input  wire pcit_pkg::pcit_byte_type  acc_value,
  input  wire pcit_pkg::pcit_addr_type  data_pointer_16,
  input  wire pcit_pkg::pcit_addr_type  return_addr,
  output pcit_pkg::pcit_addr_type       code_addr,
  output logic                          instr_first,
  output logic                          instr_last,
  output pcit_pkg::pcit_byte_type       opcode_byte,
  output pcit_pkg::pcit_byte_type       operand1_byte,
  output pcit_pkg::pcit_byte_type       operand2_byte,
  output pcit_pkg::pcit_byte_type       code_read_byte,
  output pcit_pkg::pcit_cyc_type        cycle_index,
  output logic                          xdata_req,
  output logic                          xdata_we,
  output logic                          xdata_narrow
);
  import pcit_pkg::*;

  // wrap-around address sum
  function automatic pcit_addr_type addr_add(input pcit_addr_type a,
                                             input pcit_addr_type b);
    pcit_addr_type s;
    s = a + b;
    return s;
  endfunction

  // sign-extend an 8-bit branch offset to the address width
  function automatic pcit_addr_type sext_rel(input pcit_byte_type rel);
    return {{8{rel[7]}}, rel};
  endfunction

  // registered state
  pcit_state_type state_q;    // boot or run
  pcit_state_type state_d;
  pcit_addr_type  pc_q;       // address of the current opcode
  pcit_addr_type  pc_d;
  pcit_addr_type  addr_q;     // program address on the bus
  pcit_addr_type  addr_d;
  pcit_cyc_type   cyc_q;      // cycle index inside the instruction
  pcit_cyc_type   cyc_d;
  pcit_byte_type  opc_q;      // held opcode
  pcit_byte_type  opc_d;
  pcit_byte_type  op1_q;      // held first operand byte
  pcit_byte_type  op1_d;
  pcit_byte_type  op2_q;      // held second operand byte
  pcit_byte_type  op2_d;
  pcit_byte_type  cbyte_q;    // byte returned by a code read
  pcit_byte_type  cbyte_d;
  pcit_len_type   len_q;      // held instruction length
  pcit_len_type   len_d;
  pcit_cyc_type   base_q;     // held cycle count, untaken case
  pcit_cyc_type   base_d;
  pcit_class_type cls_q;      // held timing class
  pcit_class_type cls_d;

  // live decode of the byte on the program bus
  pcit_len_type   dec_len;
  pcit_cyc_type   dec_cyc;
  pcit_class_type dec_cls;

  // decode in force for this cycle
  logic           running;    // sequencer is in run state
  logic           first;      // opcode cycle
  pcit_len_type   cur_len;
  pcit_cyc_type   cur_base;
  pcit_class_type cur_cls;
  pcit_byte_type  cur_opc;

  // address generation terms
  logic           base_end;   // last cycle of the untaken count
  logic           taken_cyc;  // extra cycle of a taken branch
  logic           is_last;    // last cycle of the instruction
  logic           redirect;   // next opcode comes from a branch target
  pcit_cyc_type   step;       // bytes fetched so far, capped at length
  pcit_addr_type  pc_after;   // address of the following instruction
  pcit_addr_type  seq_addr;   // next sequential fetch address
  pcit_addr_type  target;     // branch destination
  pcit_addr_type  code_ptr;   // address of a code byte read
  pcit_byte_type  rel_byte;   // branch offset, last byte of the branch

  // timing decode of the incoming byte
  pcit_timing_decode u_decode (
    .opc_byte (code_rdata),
    .dec_len  (dec_len),
    .dec_cyc  (dec_cyc),
    .dec_cls  (dec_cls)
  );

  // pick live decode in the opcode cycle, held decode later
  always_comb begin
    running  = (state_q == PCIT_ST_RUN);
    first    = running && (cyc_q == CYC_FIRST);
    cur_len  = first ? dec_len : len_q;
    cur_base = first ? dec_cyc : base_q;
    cur_cls  = first ? dec_cls : cls_q;
    cur_opc  = first ? code_rdata : opc_q;
  end

  // end-of-instruction detection
  always_comb begin
    base_end  = (cyc_q == (cur_base - CYC_1));
    taken_cyc = (cyc_q == cur_base);  // only reached after a true condition
    if (!running) begin  // nothing ends while booting
      is_last = 1'b0;
    end else if (cur_cls == PCIT_CLS_COND) begin
      is_last = (base_end && !branch_cond) || taken_cyc;
    end else begin
      is_last = base_end;
    end
    case (cur_cls)
      PCIT_CLS_REL, PCIT_CLS_ABS11, PCIT_CLS_ABS16,
      PCIT_CLS_JMP_IND, PCIT_CLS_RET : redirect = is_last;
      PCIT_CLS_COND                  : redirect = is_last && taken_cyc;
      default                        : redirect = 1'b0;
    endcase
  end

  // address arithmetic
  always_comb begin
    // fetch byte by byte until the length is used up, then hold
    if ((cyc_q + CYC_1) < {2'b00, cur_len}) begin
      step = cyc_q + CYC_1;
    end else begin
      step = {2'b00, cur_len};
    end
    seq_addr = addr_add(pc_q, {12'h000, step});
    pc_after = addr_add(pc_q, {14'h0000, cur_len});
    // the offset is always the last byte of the branch
    rel_byte = (cur_len == LEN_2) ? op1_q : op2_q;
    case (cur_cls)
      PCIT_CLS_REL, PCIT_CLS_COND : begin  // offset from next instruction
        target = addr_add(pc_after, sext_rel(rel_byte));
      end
      PCIT_CLS_ABS11 : begin  // page of the following instruction
        target = {pc_after[15:PC_PAGE_LSB], opc_q[OPC_PAGE_MSB:OPC_PAGE_LSB], op1_q};
      end
      PCIT_CLS_ABS16 : begin  // high byte first
        target = {op1_q, op2_q};
      end
      PCIT_CLS_JMP_IND : begin
        target = addr_add(data_pointer_16, {8'h00, acc_value});
      end
      PCIT_CLS_RET : begin
        target = return_addr;
      end
      default : begin
        target = pc_after;
      end
    endcase
    // code read base is the data pointer or the following instruction
    if (cur_opc[OPC_DATA_POINTER_16_BIT]) begin
      code_ptr = addr_add(data_pointer_16, {8'h00, acc_value});
    end else begin
      code_ptr = addr_add(pc_after, {8'h00, acc_value});
    end
  end

  // next-state logic for the sequencer
  always_comb begin
    state_d = state_q;
    pc_d    = pc_q;
    addr_d  = addr_q;
    cyc_d   = cyc_q;
    opc_d   = opc_q;
    op1_d   = op1_q;
    op2_d   = op2_q;
    cbyte_d = cbyte_q;
    len_d   = len_q;
    base_d  = base_q;
    cls_d   = cls_q;
    case (state_q)
      PCIT_ST_BOOT : begin  // address of the first opcode is already out
        state_d = PCIT_ST_RUN;
        cyc_d   = CYC_FIRST;
      end
      PCIT_ST_RUN : begin
        // capture opcode and its timing in the opcode cycle
        if (first) begin
          opc_d  = code_rdata;
          len_d  = dec_len;
          base_d = dec_cyc;
          cls_d  = dec_cls;
        end
        // operand bytes appear one per cycle
        if (cyc_q == IDX_OPND1 && cur_len != LEN_1) begin
          op1_d = code_rdata;
        end
        if (cyc_q == IDX_OPND2 && cur_len == LEN_3) begin
          op2_d = code_rdata;
        end
        // a code read returns its byte one cycle after its address
        if (cur_cls == PCIT_CLS_CODE_RD && cyc_q == IDX_CODE_DT) begin
          cbyte_d = code_rdata;
        end
        // program address for the next cycle
        if (is_last) begin
          addr_d = redirect ? target : pc_after;
          pc_d   = redirect ? target : pc_after;
          cyc_d  = CYC_FIRST;
        end else begin
          if (cur_cls == PCIT_CLS_CODE_RD && cyc_q == IDX_CODE_AD) begin
            addr_d = code_ptr;
          end else begin
            addr_d = seq_addr;
          end
          cyc_d = cyc_q + CYC_1;
        end
      end
      default : begin  // illegal state, restart cleanly
        state_d = PCIT_ST_BOOT;
        pc_d    = RESET_PC;
        addr_d  = RESET_PC;
        cyc_d   = CYC_FIRST;
      end
    endcase
  end

  // state registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= PCIT_ST_BOOT;
      pc_q    <= RESET_PC;
      addr_q  <= RESET_PC;
      cyc_q   <= CYC_FIRST;
      opc_q   <= RESET_BYTE;
      op1_q   <= RESET_BYTE;
      op2_q   <= RESET_BYTE;
      cbyte_q <= RESET_BYTE;
      len_q   <= LEN_1;
      base_q  <= CYC_1;
      cls_q   <= PCIT_CLS_SEQ;
    end else begin
      state_q <= state_d;
      pc_q    <= pc_d;
      addr_q  <= addr_d;
      cyc_q   <= cyc_d;
      opc_q   <= opc_d;
      op1_q   <= op1_d;
      op2_q   <= op2_d;
      cbyte_q <= cbyte_d;
      len_q   <= len_d;
      base_q  <= base_d;
      cls_q   <= cls_d;
    end
  end

  // outputs
  assign code_addr      = addr_q;
  assign instr_first    = first;
  assign instr_last     = is_last;
  assign opcode_byte    = opc_q;
  assign operand1_byte  = op1_q;
  assign operand2_byte  = op2_q;
  assign code_read_byte = cbyte_q;
  assign cycle_index    = cyc_q;

  // external move strobe in the second cycle
  assign xdata_req    = running && (cls_q == PCIT_CLS_EXT) && (cyc_q == IDX_XDATA);
  assign xdata_we     = opc_q[OPC_XWRITE_BIT];
  assign xdata_narrow = opc_q[OPC_XNARROW_BIT];

endmodule
`default_nettype wire

/* File: test/pcit_prog_mem.sv */
`timescale 1ns/10ps
`default_nettype none
// program memory model: one byte per address, answers in the same cycle
module pcit_prog_mem (
  input  wire pcit_pkg::pcit_addr_type code_addr,
  output pcit_pkg::pcit_byte_type      code_rdata
);
  import pcit_pkg::*;
  pcit_byte_type mem [256];  // program image, written by the bench
  // combinational read; the address wraps every 256 bytes
  assign code_rdata = mem[code_addr[7:0]];
endmodule
`default_nettype wire

/* File: test/pcit_core_sequencer_checker.sv */
`timescale 1ns/10ps
`default_nettype none
// port-level timing checks on the sequencer
module pcit_core_sequencer_checker (
  input wire logic                    core_clk,
  input wire logic                    rst_n,
  input wire pcit_pkg::pcit_byte_type code_rdata,
  input wire logic                    branch_cond,
  input wire pcit_pkg::pcit_byte_type acc_value,
  input wire pcit_pkg::pcit_addr_type data_pointer_16,
  input wire pcit_pkg::pcit_addr_type code_addr,
  input wire logic                    instr_first,
  input wire logic                    instr_last,
  input wire pcit_pkg::pcit_byte_type opcode_byte,
  input wire pcit_pkg::pcit_cyc_type  cycle_index,
  input wire logic                    xdata_req,
  input wire logic                    xdata_we,
  input wire logic                    xdata_narrow
);
  import pcit_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // opcode fetch of a new instruction in the cycle after one ends
  AST_NEXT_OPENS: assert property (instr_last |=> instr_first)
    else $error("no opcode cycle after a closing cycle");
  // the opcode cycle is index zero
  AST_FIRST_IDX: assert property (instr_first |-> cycle_index == CYC_FIRST)
    else $error("opcode cycle index not zero");
  // index advances by one every clock inside an instruction
  AST_IDX_STEP: assert property (
    (!instr_last && (instr_first || cycle_index != CYC_FIRST))
    |=> cycle_index == $past(cycle_index) + CYC_1)
    else $error("cycle index did not step by one");
  // second cycle of any longer instruction fetches the next byte
  AST_ADDR_STEP: assert property (
    (instr_first && !instr_last) |=> code_addr == $past(code_addr) + 16'h0001)
    else $error("program address did not step");
  // single-cycle opcodes
  AST_ONE_CYCLE: assert property (
    (instr_first && code_rdata inside {[8'h28:8'h2f], 8'he4, 8'hf4, 8'h23, 8'h33, 8'h03,
    8'h13, 8'hc4, 8'hd4, 8'hc3, 8'hd3, 8'hb3, 8'ha5, 8'h00}) |-> instr_last)
    else $error("single-cycle opcode did not end at once");
  // indirect RAM forms take two cycles
  AST_TWO_CYCLE: assert property (
    (instr_first && code_rdata inside {8'h26, 8'h27, 8'h56, 8'h57, 8'h46, 8'h47, 8'h66,
    8'h67, 8'hf6, 8'hf7, 8'hc6, 8'hc7, 8'hd6, 8'hd7}) |-> !instr_last ##1 instr_last)
    else $error("indirect opcode not two cycles");
  // multiply takes four cycles
  AST_MUL: assert property (
    (instr_first && code_rdata == 8'ha4) |-> (!instr_last)[*3] ##1 instr_last)
    else $error("multiply not four cycles");
  // divide takes eight cycles
  AST_DIV: assert property (
    (instr_first && code_rdata == 8'h84) |-> (!instr_last)[*7] ##1 instr_last)
    else $error("divide not eight cycles");
  // external move strobe in cycle one, direction and width from the fetched opcode
  AST_XDATA: assert property (
    (instr_first && code_rdata inside {8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3})
    |=> (xdata_req && xdata_we == $past(code_rdata[OPC_XWRITE_BIT])
    && xdata_narrow == $past(code_rdata[OPC_XNARROW_BIT])) ##1 (instr_last && !xdata_req))
    else $error("external move strobe wrong");
  // data-pointer code read (93): address is data pointer plus accumulator in the last cycle
  AST_CODE_RD: assert property (
    (instr_first && code_rdata == 8'h93)
    |-> ##2 (instr_last && code_addr == data_pointer_16 + {8'h00, acc_value}))
    else $error("code read address or length wrong");
  // untaken branch ends in cycle one
  AST_COND_FALSE: assert property (
    (instr_first && code_rdata == 8'h40) ##1 !branch_cond |-> instr_last)
    else $error("untaken branch not two cycles");
  // taken branch ends one cycle later
  AST_COND_TRUE: assert property (
    (instr_first && code_rdata == 8'h40) ##1 branch_cond |-> !instr_last ##1 instr_last)
    else $error("taken branch not three cycles");
  COV_DIV: cover property (instr_first && code_rdata == 8'h84);
  COV_XWRITE: cover property (xdata_req && xdata_we);
  COV_TAKEN: cover property ((instr_first && code_rdata == 8'h40) ##1 branch_cond);
endmodule
`default_nettype wire

/* File: test/pipelined_core_instruction_timing_tb.sv */
`timescale 1ns/10ps
`default_nettype none
// self-checking bench for the instruction timing sequencer
module pipelined_core_instruction_timing_tb;
  import pcit_pkg::*;
  logic          core_clk = 1'b0;             // system clock
  logic          rst_n = 1'b0;                // async reset
  logic          branch_cond = 1'b0;          // branch condition level
  pcit_byte_type acc_value = 8'h00;           // accumulator value
  pcit_addr_type data_pointer_16 = 16'h0000;  // data pointer value
  pcit_addr_type return_addr = 16'h0000;      // return target
  pcit_byte_type code_rdata;                  // byte from the memory model
  pcit_addr_type code_addr;                   // program address
  logic          instr_first, instr_last;     // instruction boundaries
  logic          xdata_req, xdata_we, xdata_narrow;
  pcit_byte_type opcode_byte, operand1_byte, operand2_byte, code_read_byte;
  pcit_cyc_type  cycle_index;
  int            n_mismatch = 0;              // mismatches seen
  int            compares = 0;                // comparisons made
  logic [15:0]   tbl[$];                      // {opcode, length, cycles}
  pcit_addr_type exp_pc[$];                   // expected start addresses
  pcit_cyc_type  exp_cyc[$];                  // expected cycle counts
  pcit_byte_type exp_op[$];                   // opcodes in order

  // 50 MHz clock
  always #10 core_clk = ~core_clk;

  pcit_core_sequencer uut (
    .core_clk(core_clk), .rst_n(rst_n), .code_rdata(code_rdata),
    .branch_cond(branch_cond), .acc_value(acc_value), .data_pointer_16(data_pointer_16),
    .return_addr(return_addr), .code_addr(code_addr), .instr_first(instr_first),
    .instr_last(instr_last), .opcode_byte(opcode_byte), .operand1_byte(operand1_byte),
    .operand2_byte(operand2_byte), .code_read_byte(code_read_byte),
    .cycle_index(cycle_index), .xdata_req(xdata_req), .xdata_we(xdata_we),
    .xdata_narrow(xdata_narrow)
  );
  pcit_prog_mem mem_i (.code_addr(code_addr), .code_rdata(code_rdata));

  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] expd);
    compares++;
    if (seen !== expd) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask

  // verdict and end of run
  task automatic results();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // hold the core in reset, fill memory with no-operations
  task automatic clr();
    rst_n = 1'b0;
    foreach (mem_i.mem[i]) mem_i.mem[i] = 8'h00;
    exp_pc.delete();
    exp_cyc.delete();
    exp_op.delete();
  endtask

  // lay the table out from address zero, operand bytes zero
  task automatic lay();
    int pc;
    clr();
    pc = 0;
    foreach (tbl[i]) begin
      mem_i.mem[pc] = tbl[i][15:8];
      exp_pc.push_back(16'(pc));
      exp_op.push_back(tbl[i][15:8]);
      exp_cyc.push_back(tbl[i][3:0]);
      pc += int'(tbl[i][7:4]);
    end
  endtask

  // release reset and judge every expected instruction
  task automatic run();
    int n;
    int x;
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    foreach (exp_pc[i]) begin
      n = 0;
      while (instr_first !== 1'b1 && n < 20) begin
        @(negedge core_clk);
        n++;
      end
      check(code_addr, exp_pc[i]);
      n = 1;
      x = 0;
      while (1) begin
        if (xdata_req === 1'b1) begin
          x++;
          check({xdata_we, xdata_narrow}, {exp_op[i][4], exp_op[i][1]});
        end
        if (instr_last === 1'b1 || n > 20) break;
        @(negedge core_clk);
        n++;
      end
      check(16'(n), 16'(exp_cyc[i]));
      check(16'(x), {15'h0000, (exp_op[i] inside {8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2,
        8'hf3})});
      @(negedge core_clk);
      check(opcode_byte, exp_op[i]);
    end
  endtask

  // arithmetic: register, direct, indirect, multiply, divide
  task automatic test_arith();
    tbl = '{16'h2811, 16'h3911, 16'h9a11, 16'h2522, 16'h3522, 16'h9522, 16'h2612,
      16'h5712, 16'h4612, 16'h6712, 16'ha414, 16'h8418};
    lay();
    run();
    $display("arithmetic timing checked");
  endtask

  // logic into direct bytes and accumulator-only operations
  task automatic test_logic();
    tbl = '{16'h5333, 16'h4333, 16'h6333, 16'h5222, 16'h4222, 16'h6222, 16'he411,
      16'hf411, 16'h2311, 16'h3311, 16'h0311, 16'h1311, 16'hc411, 16'hd411};
    lay();
    run();
    $display("logic timing checked");
  endtask

  // data moves, stack, exchanges, bit operations, unused opcode
  task automatic test_move();
    tbl = '{16'h9033, 16'h8533, 16'hf612, 16'h7822, 16'hc022, 16'hd022, 16'hc612,
      16'hd612, 16'hc311, 16'hd311, 16'hb311, 16'hc222, 16'hd222, 16'hb222, 16'ha511,
      16'h0011};
    lay();
    mem_i.mem[5] = 8'h5a;
    run();
    check(operand2_byte, 8'h5a);
    $display("move timing checked");
  endtask

  // all six external moves, back to back
  task automatic test_ext();
    tbl = '{16'he013, 16'he213, 16'he313, 16'hf013, 16'hf213, 16'hf313};
    lay();
    run();
    $display("external move timing checked");
  endtask

  // conditional branches with zero offset, taken or not
  task automatic test_cond(input logic taken);
    branch_cond = taken;
    if (taken) begin
      tbl = '{16'h4023, 16'h2034, 16'hb545};
    end else begin
      tbl = '{16'h4022, 16'h2033, 16'hb544};
    end
    lay();
    run();
    $display("conditional branch timing checked");
  endtask

  // forward then backward relative offsets
  task automatic test_rel();
    clr();
    branch_cond = 1'b1;
    mem_i.mem[0] = 8'h40;
    mem_i.mem[1] = 8'h03;
    mem_i.mem[5] = 8'h80;
    mem_i.mem[6] = 8'hfb;
    exp_pc = '{16'h0000, 16'h0005, 16'h0002};
    exp_cyc = '{4'h3, 4'h3, 4'h1};
    exp_op = '{8'h40, 8'h80, 8'h00};
    run();
    check(operand1_byte, 8'hfb);
    $display("relative offsets checked");
  endtask

  // code reads based on data pointer and on program counter
  task automatic test_code_rd();
    acc_value = 8'h20;
    data_pointer_16 = 16'h0040;
    tbl = '{16'h9313};
    lay();
    mem_i.mem[8'h60] = 8'ha1;
    run();
    check(code_read_byte, 8'ha1);
    tbl = '{16'h0011, 16'h8313};
    lay();
    mem_i.mem[8'h22] = 8'hb2;
    run();
    check(code_read_byte, 8'hb2);
    $display("code read checked");
  endtask

  // main sequence
  initial begin
    test_arith();
    test_logic();
    test_move();
    test_ext();
    test_cond(1'b0);
    test_cond(1'b1);
    test_rel();
    test_code_rd();
    results();
  end

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (4000) @(posedge core_clk);
    n_mismatch++;
    results();
  end
endmodule

bind pcit_core_sequencer pcit_core_sequencer_checker chk (
  .core_clk(core_clk), .rst_n(rst_n), .code_rdata(code_rdata), .branch_cond(branch_cond),
  .acc_value(acc_value), .data_pointer_16(data_pointer_16), .code_addr(code_addr),
  .instr_first(instr_first), .instr_last(instr_last), .opcode_byte(opcode_byte),
  .cycle_index(cycle_index), .xdata_req(xdata_req), .xdata_we(xdata_we),
  .xdata_narrow(xdata_narrow)
);
`default_nettype wire
